// ### core/can_lp_pkg.sv
package can_lp_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_RFLG = 8'h08;
   localparam logic [7:0] OFS_RIER = 8'h0C;
   localparam logic [7:0] OFS_TFLG = 8'h10;
   localparam logic [7:0] OFS_TIER = 8'h14;
   localparam logic [7:0] OFS_TARQ = 8'h18;
   localparam logic [7:0] OFS_TAAK = 8'h1C;
   localparam logic [7:0] OFS_TBSEL = 8'h20;
   localparam logic [7:0] OFS_BTR0 = 8'h24;
   localparam logic [7:0] OFS_BTR1 = 8'h28;
   localparam logic [7:0] OFS_IDAC = 8'h2C;
   localparam logic [7:0] OFS_STAT = 8'h30;

   // ****************************************
   // Field positions
   // ****************************************
   // control_reg_zero
   localparam int B_INIT_REQUEST_BIT = 0;
   localparam int B_SLEEP_REQUEST_BIT = 1;
   localparam int B_WAKEUP_ENABLE_BIT = 2;
   localparam int B_STOP_IN_WAIT_BIT = 5;
   // control_reg_one
   localparam int B_INIT_ACK_BIT = 0;
   localparam int B_SLEEP_ACK_BIT = 1;
   localparam int B_WAKEUP_FILTER_SELECT = 2;
   // rx_flag_reg
   localparam int B_RXF = 0;
   localparam int B_OVERRUN_FLAG = 1;
   localparam int B_STATUS_CHANGE_FLAG = 6;
   localparam int B_WAKEUP_INT_FLAG = 7;
   localparam int B_TX_STATE_FIELD = 2;
   localparam int B_RX_STATE_FIELD = 4;

   // ****************************************
   // Reset values and timing
   // ****************************************
   localparam logic [7:0] RST_CTRL0 = 8'h01;
   localparam logic [7:0] RST_TFLG = 8'h07;
   localparam logic [7:0] RST_TBSEL = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam int SYNC_DLY = 3;
   localparam int RECOV_DLY = 8;
   localparam int IDLE_BITS = 11;
   localparam int WUP_FILT = 4;

   typedef enum logic [1:0] {ST_OK, ST_WARN, ST_ERR, ST_BOFF} bus_state_e;

   // Protocol engine status toward the mode logic
   typedef struct packed {
      logic tx_busy;
      logic rx_busy;
      logic bus_idle;
      logic rx_bit_tick;
      logic rx_done;
      logic overrun;
      bus_state_e tx_state;
      bus_state_e rx_state;
   } eng_stat_s;

   // Mode logic commands toward the protocol engine
   typedef struct packed {
      logic eng_run;
      logic eng_abort;
      logic move_fg;
      logic boff_count_en;
      logic [2:0] abort_req;
   } eng_ctrl_s;

endpackage : can_lp_pkg

// ### core/can_lp_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - Sleep waits until all tx buffers empty
// - Sleep during reception waits for bus idle
// - Idle controller sleeps after sync delay
// - Sleep holds request and acknowledge both set
// - Sleep stops core, registers stay accessible
// - Bus-off recovery count paused in sleep
// - Transmit output recessive while sleeping
// - Sleep: rx readable, no move, no abort
// - Wake-up disabled in sleep masks receive input recessive
// - Leave sleep on bus activity or clear
// - Sleep request clear ignored until acknowledged
// - After wake wait eleven recessive bits
// - Deferred moves, aborts, transmits run on wake
// - Init mode aborts traffic, forces recessive
// - Init mode resets control and flag registers
// - Init request synchronised before acknowledge sets
// - Init request clear ignored until acknowledged
// - Power down on stop or wait-stop
// - Power down: no access, recovery delay after unless back to sleep
// - Four maskable interrupt sources, three tx enables
// - Receive full sets when foreground loaded
// - Error flag on overrun or state change
// - Flags clear by writing one, condition wins
module can_lp_ctrl #(
   parameter int NTX = 3
) (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU low power state
   input wire logic cpu_stop,
   input wire logic cpu_wait,
   // CAN pins and engine
   input wire logic can_rx_input,
   input wire logic can_tx_engine,
   input wire can_lp_pkg::eng_stat_s eng_stat,
   output can_lp_pkg::eng_ctrl_s eng_ctrl,
   output logic can_tx_output,
   output logic can_rx_internal,
   // Interrupt lines
   output logic irq_wakeup,
   output logic irq_error,
   output logic irq_rx,
   output logic irq_tx
);
   import can_lp_pkg::*;

   typedef enum {M_NORM, M_SLP_PEND, M_SLEEP, M_RESYNC, M_INIT_SYNC, M_INIT, M_PDOWN,
                 M_RECOV} mode_e;

   mode_e mode_r;
   logic init_rq_r, slp_rq_r, wakeup_enable_bit_r, stop_in_wait_bit_r, wakeup_filter_select_r;
   logic init_ak_r, slp_ak_r;
   logic rxf_r, ovr_r, csc_r, wup_r;
   logic [7:0] rier_r, tier_r, tarq_r, taak_r, tbsel_r, btr0_r, btr1_r, idac_r;
   logic [NTX-1:0] txe_r;
   logic [3:0] cnt_r;
   logic [3:0] rbits_r;
   logic slp_before_r;
   logic [1:0] tx_st_r, rx_st_r;
   logic [31:0] rdata_nxt;
   logic wr, rd_acc, acc_first, pdown, acts, rx_dom, wake_ev;

   // ****************************************
   // Bus decode helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] ofs);
      return paddr == ofs;
   endfunction : hit

   // Register access blocked in power down
   assign acc_first = psel && penable && !pready && !pdown;
   assign acts = psel && penable && pready && !pdown;
   assign wr = acts && pwrite;
   assign rd_acc = acc_first && !pwrite;
   assign pdown = cpu_stop || (cpu_wait && stop_in_wait_bit_r);
   assign rx_dom = !can_rx_input;

   // ****************************************
   // Mode sequencer
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= M_INIT;
         cnt_r <= '0;
         slp_before_r <= 1'b0;
         rbits_r <= '0;
      end else if (ce) begin
         case (mode_r)
            M_NORM: begin
               if (pdown) begin
                  slp_before_r <= 1'b0;
                  mode_r <= M_PDOWN;
               end else if (init_rq_r) begin
                  cnt_r <= 4'(SYNC_DLY);
                  mode_r <= M_INIT_SYNC;
               end else if (slp_rq_r) begin
                  cnt_r <= 4'(SYNC_DLY);
                  mode_r <= M_SLP_PEND;
               end
            end
            M_SLP_PEND: begin
               if (pdown) begin
                  slp_before_r <= 1'b0;
                  mode_r <= M_PDOWN;
               end else if (init_rq_r) begin
                  cnt_r <= 4'(SYNC_DLY);
                  mode_r <= M_INIT_SYNC;
               end else if (cnt_r != 4'h0) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (&txe_r && !eng_stat.tx_busy && !eng_stat.rx_busy
                            && eng_stat.bus_idle) begin
                  mode_r <= M_SLEEP;
               end
            end
            M_SLEEP: begin
               if (pdown) begin
                  slp_before_r <= 1'b1;
                  mode_r <= M_PDOWN;
               end else if (init_rq_r) begin
                  cnt_r <= 4'(SYNC_DLY);
                  mode_r <= M_INIT_SYNC;
               end else if (wake_ev || !slp_rq_r) begin
                  rbits_r <= '0;
                  mode_r <= M_RESYNC;
               end
            end
            M_RESYNC: begin
               if (can_rx_input && eng_stat.rx_bit_tick) begin
                  if (rbits_r == 4'(IDLE_BITS - 1)) mode_r <= M_NORM;
                  else rbits_r <= rbits_r + 4'h1;
               end else if (rx_dom && eng_stat.rx_bit_tick) begin
                  rbits_r <= '0;
               end
            end
            M_INIT_SYNC: begin
               if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
               else mode_r <= M_INIT;
            end
            M_INIT: begin
               if (!init_rq_r) mode_r <= slp_rq_r ? M_SLEEP : M_NORM;
            end
            M_PDOWN: begin
               if (!pdown) begin
                  cnt_r <= 4'(RECOV_DLY);
                  mode_r <= slp_before_r ? M_SLEEP : M_RECOV;
               end
            end
            M_RECOV: begin
               if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
               else mode_r <= M_NORM;
            end
            default: mode_r <= M_INIT;
         endcase
      end
   end

   // ****************************************
   // Wake-up filter
   // ****************************************
   logic [1:0] wfilt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) wfilt_r <= '0;
      else if (ce) begin
         if (mode_r != M_SLEEP || !rx_dom) wfilt_r <= '0;
         else if (wfilt_r != 2'(WUP_FILT - 1)) wfilt_r <= wfilt_r + 2'h1;
      end
   end
   // Wake only with enable set; else input seen recessive
   assign wake_ev = wakeup_enable_bit_r && rx_dom && (!wakeup_filter_select_r || wfilt_r == 2'(WUP_FILT - 1));

   // ****************************************
   // Control registers and handshakes
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_rq_r <= RST_CTRL0[B_INIT_REQUEST_BIT];
         slp_rq_r <= 1'b0;
         wakeup_enable_bit_r <= 1'b0;
         stop_in_wait_bit_r <= 1'b0;
         wakeup_filter_select_r <= 1'b0;
         init_ak_r <= 1'b0;
         slp_ak_r <= 1'b0;
      end else if (ce) begin
         init_ak_r <= (mode_r == M_INIT);
         slp_ak_r <= (mode_r == M_SLEEP) && slp_rq_r;
         if (wr && hit(OFS_CTRL0)) begin
            stop_in_wait_bit_r <= pwdata[B_STOP_IN_WAIT_BIT];
            if (mode_r != M_INIT) wakeup_enable_bit_r <= pwdata[B_WAKEUP_ENABLE_BIT];
            if (pwdata[B_INIT_REQUEST_BIT] || (init_rq_r && init_ak_r))
               init_rq_r <= pwdata[B_INIT_REQUEST_BIT];
            if (pwdata[B_SLEEP_REQUEST_BIT] || (slp_rq_r && slp_ak_r))
               slp_rq_r <= pwdata[B_SLEEP_REQUEST_BIT];
         end else if (mode_r == M_INIT) begin
            slp_rq_r <= 1'b0;
            wakeup_enable_bit_r <= 1'b0;
         end else if (mode_r == M_SLEEP && wake_ev) begin
            slp_rq_r <= 1'b0;
         end
         if (wr && hit(OFS_CTRL1) && mode_r == M_INIT) wakeup_filter_select_r <= pwdata[B_WAKEUP_FILTER_SELECT];
      end
   end

   // ****************************************
   // Flags, enables, buffer control
   // ****************************************
   logic in_init, in_sleep, csc_ev;
   assign in_init = mode_r == M_INIT;
   assign in_sleep = mode_r == M_SLEEP;
   assign csc_ev = (eng_stat.tx_state != bus_state_e'(tx_st_r))
                || (eng_stat.rx_state != bus_state_e'(rx_st_r));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rxf_r, ovr_r, csc_r, wup_r} <= '0;
         {rier_r, tier_r, tarq_r, taak_r} <= '0;
         tbsel_r <= RST_TBSEL;
         txe_r <= '1;
         tx_st_r <= '0;
         rx_st_r <= '0;
         {btr0_r, btr1_r, idac_r} <= '0;
      end else if (ce) begin
         tx_st_r <= 2'(eng_stat.tx_state);
         rx_st_r <= 2'(eng_stat.rx_state);
         if (in_init) begin
            {rxf_r, ovr_r, csc_r, wup_r} <= '0;
            {rier_r, tier_r, tarq_r, taak_r} <= '0;
            tbsel_r <= RST_TBSEL;
            txe_r <= '1;
            if (wr && hit(OFS_BTR0)) btr0_r <= pwdata[7:0];
            if (wr && hit(OFS_BTR1)) btr1_r <= pwdata[7:0];
            if (wr && hit(OFS_IDAC)) idac_r <= pwdata[7:0];
         end else begin
            // Set beats a same-cycle write-one clear
            if (eng_stat.rx_done && !in_sleep) rxf_r <= 1'b1;
            else if (wr && hit(OFS_RFLG) && pwdata[B_RXF]) rxf_r <= 1'b0;
            if (eng_stat.overrun) ovr_r <= 1'b1;
            else if (wr && hit(OFS_RFLG) && pwdata[B_OVERRUN_FLAG]) ovr_r <= 1'b0;
            if (csc_ev) csc_r <= 1'b1;
            else if (wr && hit(OFS_RFLG) && pwdata[B_STATUS_CHANGE_FLAG]) csc_r <= 1'b0;
            if (in_sleep && wake_ev) wup_r <= 1'b1;
            else if (wr && hit(OFS_RFLG) && pwdata[B_WAKEUP_INT_FLAG]) wup_r <= 1'b0;
            if (wr && hit(OFS_RIER)) rier_r <= pwdata[7:0];
            if (wr && hit(OFS_TIER)) tier_r <= pwdata[7:0];
            if (wr && hit(OFS_TBSEL)) tbsel_r <= pwdata[7:0];
            if (wr && hit(OFS_TARQ)) tarq_r <= pwdata[7:0];
            // Scheduling allowed in sleep: clear to one, abort request sets it back outside sleep
            for (int i = 0; i < NTX; i++) begin
               if (!in_sleep && (taak_r[i] || tarq_r[i])) txe_r[i] <= 1'b1;
               else if (wr && hit(OFS_TFLG) && pwdata[i]) txe_r[i] <= 1'b0;
               if (!in_sleep && tarq_r[i] && !txe_r[i]) taak_r[i] <= 1'b1;
               else if (txe_r[i]) taak_r[i] <= 1'b0;
               if (txe_r[i]) tarq_r[i] <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Outputs to pins, engine, interrupts
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_tx_output <= 1'b1;
         can_rx_internal <= 1'b1;
         eng_ctrl <= '0;
         {irq_wakeup, irq_error, irq_rx, irq_tx} <= '0;
      end else if (ce) begin
         // Recessive in sleep, init and power down
         can_tx_output <= ((mode_r == M_NORM || mode_r == M_SLP_PEND) && !pdown) ?
                          can_tx_engine : 1'b1;
         can_rx_internal <= (in_sleep && !wakeup_enable_bit_r) ? 1'b1 : can_rx_input;
         // Core clocks gated off outside running modes
         eng_ctrl.eng_run <= mode_r == M_NORM || mode_r == M_SLP_PEND || mode_r == M_RESYNC;
         eng_ctrl.eng_abort <= in_init || mode_r == M_INIT_SYNC || pdown;
         eng_ctrl.move_fg <= !in_sleep && !in_init && !rxf_r;
         eng_ctrl.boff_count_en <= !in_sleep && !pdown;
         eng_ctrl.abort_req <= in_sleep ? '0 : tarq_r[2:0];
         irq_wakeup <= wup_r && rier_r[B_WAKEUP_INT_FLAG];
         irq_error <= (csc_r && rier_r[B_STATUS_CHANGE_FLAG]) || (ovr_r && rier_r[B_OVERRUN_FLAG]);
         irq_rx <= rxf_r && rier_r[B_RXF];
         irq_tx <= |(txe_r & tier_r[NTX-1:0]);
      end
   end

   // ****************************************
   // APB read path
   // ****************************************
   always_comb begin
      rdata_nxt = '0;
      case (paddr)
         OFS_CTRL0: rdata_nxt[7:0] = {2'b00, stop_in_wait_bit_r, 2'b00, wakeup_enable_bit_r, slp_rq_r, init_rq_r};
         OFS_CTRL1: rdata_nxt[7:0] = {5'h00, wakeup_filter_select_r, slp_ak_r, init_ak_r};
         OFS_RFLG: rdata_nxt[7:0] = {wup_r, csc_r, rx_st_r, tx_st_r, ovr_r, rxf_r};
         OFS_RIER: rdata_nxt[7:0] = rier_r;
         OFS_TFLG: rdata_nxt[NTX-1:0] = txe_r;
         OFS_TIER: rdata_nxt[7:0] = tier_r;
         OFS_TARQ: rdata_nxt[7:0] = tarq_r;
         OFS_TAAK: rdata_nxt[7:0] = taak_r;
         OFS_TBSEL: rdata_nxt[7:0] = tbsel_r;
         OFS_BTR0: rdata_nxt[7:0] = btr0_r;
         OFS_BTR1: rdata_nxt[7:0] = btr1_r;
         OFS_IDAC: rdata_nxt[7:0] = idac_r;
         OFS_STAT: rdata_nxt[3:0] = 4'(mode_r);
         default: rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         // One wait state; answer withheld during power down
         pready <= acc_first;
         pslverr <= acc_first && paddr > OFS_STAT;
         if (rd_acc) prdata <= rdata_nxt;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   AST_SLEEP_TX_REC: assert property (@(posedge pclk) disable iff (!presetn)
      ce && $past(ce) && $past(mode_r == M_SLEEP) |-> can_tx_output)
      else $error("tx not recessive in sleep");
   AST_SLP_HANDSHAKE: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ce) && slp_ak_r |-> $past(slp_rq_r && mode_r == M_SLEEP))
      else $error("sleep ack without request");
   AST_SLP_CLR_IGN: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr && hit(OFS_CTRL0) && slp_rq_r && !slp_ak_r |=> slp_rq_r)
      else $error("sleep request cleared early");
   AST_INIT_CLR_IGN: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr && hit(OFS_CTRL0) && init_rq_r && !init_ak_r |=> init_rq_r)
      else $error("init request cleared early");
   AST_INIT_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(init_ak_r) |-> $past(init_rq_r, 2))
      else $error("init ack too early");
   AST_SLEEP_TXE: assert property (@(posedge pclk) disable iff (!presetn)
      mode_r == M_SLP_PEND ##1 mode_r == M_SLEEP |-> $past(&txe_r))
      else $error("sleep with tx scheduled");
   AST_NO_FG_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
      ce && in_sleep && !rxf_r && !(wr && hit(OFS_RFLG)) |=> !rxf_r)
      else $error("rx moved in sleep");
   AST_PDOWN_TX: assert property (@(posedge pclk) disable iff (!presetn)
      ce && pdown ##1 ce |-> can_tx_output)
      else $error("tx active in power down");
   COV_SLEEP: cover property (@(posedge pclk) mode_r == M_SLP_PEND ##[1:100] mode_r == M_SLEEP);
   COV_WAKE: cover property (@(posedge pclk) in_sleep && wake_ev);
   COV_INIT: cover property (@(posedge pclk) $rose(init_ak_r));
   COV_PDOWN: cover property (@(posedge pclk) mode_r == M_RECOV);

endmodule : can_lp_ctrl

// ### sim/can_lp_bus_model.sv
`timescale 1ns/100ps
module can_lp_bus_model #(
   parameter int BIT_CYC = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Scenario controls
   input wire logic rx_active,
   input wire logic tx_dom,
   input wire logic bus_dom,
   input wire logic done_ev,
   input wire logic ovr_ev,
   input wire can_lp_pkg::bus_state_e tx_st,
   // Controller side
   input wire can_lp_pkg::eng_ctrl_s eng_ctrl,
   input wire logic can_tx_output,
   output can_lp_pkg::eng_stat_s eng_stat,
   output logic can_rx_input,
   output logic can_tx_engine
);
   import can_lp_pkg::*;

   logic [7:0] bit_cnt_r;

   // ****************************************
   // Bit time of the far nodes
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_r <= 8'h00;
      end else if (bit_cnt_r == 8'(BIT_CYC - 1)) begin
         bit_cnt_r <= 8'h00;
      end else begin
         bit_cnt_r <= bit_cnt_r + 8'h01;
      end
   end

   // ****************************************
   // Wired-and bus and engine status
   // ****************************************
   // Any dominant node wins, the controller's own pin included
   assign can_rx_input = !bus_dom && can_tx_output;
   assign can_tx_engine = !tx_dom;
   // An abort from the controller ends the frame being received
   assign eng_stat = '{tx_busy: tx_dom, rx_busy: rx_active && !eng_ctrl.eng_abort,
                       bus_idle: !rx_active && can_rx_input, rx_bit_tick: bit_cnt_r == 8'h00,
                       rx_done: done_ev, overrun: ovr_ev, tx_state: tx_st, rx_state: ST_OK};

endmodule : can_lp_bus_model

// ### sim/can_low_power_and_interrupts_tb_top.sv
`timescale 1ns/100ps
module can_low_power_and_interrupts_tb_top;
   import can_lp_pkg::*;

   localparam int P_TX = 0;
   localparam int P_RI = 1;
   localparam int P_WK = 2;
   localparam int P_ER = 3;
   localparam int P_RX = 4;
   localparam int P_IT = 5;
   localparam int P_RN = 6;
   localparam int P_BO = 7;
   localparam int P_MV = 8;
   localparam int P_AB = 9;

   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic cpu_stop, cpu_wait, can_rx_input, can_tx_engine, can_tx_output, can_rx_internal;
   logic irq_wakeup, irq_error, irq_rx, irq_tx, err_v;
   logic rx_active, tx_dom, bus_dom, done_ev, ovr_ev;
   bus_state_e tx_st;
   eng_stat_s eng_stat;
   eng_ctrl_s eng_ctrl;
   logic [9:0] pins;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;

   assign pins = {eng_ctrl.eng_abort, eng_ctrl.move_fg, eng_ctrl.boff_count_en, eng_ctrl.eng_run,
                  irq_tx, irq_rx, irq_error, irq_wakeup, can_rx_internal, can_tx_output};

   can_lp_ctrl u_can_lp_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
      .can_rx_input(can_rx_input), .can_tx_engine(can_tx_engine), .eng_stat(eng_stat),
      .eng_ctrl(eng_ctrl), .can_tx_output(can_tx_output), .can_rx_internal(can_rx_internal),
      .irq_wakeup(irq_wakeup), .irq_error(irq_error), .irq_rx(irq_rx), .irq_tx(irq_tx));

   can_lp_bus_model u_can_lp_bus_model (.pclk(pclk), .presetn(presetn), .rx_active(rx_active),
      .tx_dom(tx_dom), .bus_dom(bus_dom), .done_ev(done_ev), .ovr_ev(ovr_ev), .tx_st(tx_st),
      .eng_ctrl(eng_ctrl), .can_tx_output(can_tx_output), .eng_stat(eng_stat),
      .can_rx_input(can_rx_input), .can_tx_engine(can_tx_engine));

   // ****************************************
   // Clock, reset and hang guard
   // ****************************************
   initial pclk = 1'b0;
   always #10 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   // ****************************************
   // Bus cycles and comparisons
   // ****************************************
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Active-region read sees the value sampled at this edge
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pin

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd_v, err_v);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rd_v, err_v);
      chk_reg(rd_v, exp);
   endtask : rd_chk

   // Masked read, repeated a bounded number of times until it matches
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      for (int i = 0; i < 60; i++) begin
         apb(1'b0, a, 32'h0, rd_v, err_v);
         if ((rd_v & m) === exp) break;
      end
      chk_reg(rd_v & m, exp);
   endtask : poll

   // Outputs are registered, so give them two edges to settle
   task automatic pin_chk(input int sel, input logic exp);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk_pin(pins[sel], exp);
      @(posedge pclk);
   endtask : pin_chk

   task automatic ev(input logic d, input logic o);
      @(posedge pclk);
      done_ev <= d;
      ovr_ev <= o;
      @(posedge pclk);
      done_ev <= 1'b0;
      ovr_ev <= 1'b0;
   endtask : ev

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, mismatches);
   endtask : end_test

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      {presetn, psel, penable, pwrite, cpu_stop, cpu_wait} = 6'h00;
      {rx_active, tx_dom, bus_dom, done_ev, ovr_ev} = 5'h00;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx_st = ST_OK;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(OFS_CTRL0, 32'h1);
      rd_chk(OFS_TFLG, 32'h7);
      rd_chk(OFS_RIER, 32'h0);
      poll(OFS_CTRL1, 32'h1, 32'h1);
      apb(1'b0, 8'h34, 32'h0, rd_v, err_v);
      chk_reg(rd_v, 32'h0);
      chk_pin(err_v, 1'b1);
      tx_dom <= 1'b1;
      pin_chk(P_TX, 1'b1);
      pin_chk(P_AB, 1'b1);
      wr(OFS_BTR0, 32'h5A);
      rd_chk(OFS_BTR0, 32'h5A);
      wr(OFS_CTRL0, 32'h0);
      poll(OFS_CTRL1, 32'h1, 32'h0);
      repeat (120) @(posedge pclk);
      pin_chk(P_TX, 1'b0);
      pin_chk(P_AB, 1'b0);
      wr(OFS_BTR0, 32'hA5);
      rd_chk(OFS_BTR0, 32'h5A);
      tx_dom <= 1'b0;
      end_test("init");
      wr(OFS_TIER, 32'h7);
      pin_chk(P_IT, 1'b1);
      wr(OFS_TFLG, 32'h1);
      rd_chk(OFS_TFLG, 32'h6);
      wr(OFS_TIER, 32'h1);
      pin_chk(P_IT, 1'b0);
      wr(OFS_RIER, 32'hC3);
      ev(1'b1, 1'b0);
      poll(OFS_RFLG, 32'h1, 32'h1);
      pin_chk(P_RX, 1'b1);
      wr(OFS_RFLG, 32'h1);
      poll(OFS_RFLG, 32'h1, 32'h0);
      pin_chk(P_RX, 1'b0);
      ev(1'b0, 1'b1);
      poll(OFS_RFLG, 32'h2, 32'h2);
      pin_chk(P_ER, 1'b1);
      tx_st <= ST_WARN;
      poll(OFS_RFLG, 32'h4C, 32'h44);
      wr(OFS_RFLG, 32'h42);
      poll(OFS_RFLG, 32'hC3, 32'h0);
      pin_chk(P_ER, 1'b0);
      end_test("flags");
      wr(OFS_CTRL0, 32'h2);
      repeat (30) @(posedge pclk);
      rd_chk(OFS_CTRL1, 32'h0);
      wr(OFS_CTRL0, 32'h3);
      rd_chk(OFS_CTRL1, 32'h0);
      poll(OFS_CTRL1, 32'h1, 32'h1);
      rd_chk(OFS_TFLG, 32'h7);
      rd_chk(OFS_RIER, 32'h0);
      wr(OFS_CTRL0, 32'h0);
      poll(OFS_CTRL1, 32'h1, 32'h0);
      wr(OFS_CTRL0, 32'h1);
      wr(OFS_CTRL0, 32'h0);
      poll(OFS_CTRL1, 32'h1, 32'h1);
      rd_chk(OFS_CTRL0, 32'h1);
      wr(OFS_CTRL0, 32'h0);
      poll(OFS_CTRL1, 32'h1, 32'h0);
      repeat (120) @(posedge pclk);
      end_test("tx_pending_and_init");
      rx_active <= 1'b1;
      wr(OFS_CTRL0, 32'h2);
      repeat (30) @(posedge pclk);
      rd_chk(OFS_CTRL1, 32'h0);
      wr(OFS_CTRL0, 32'h0);
      rd_chk(OFS_CTRL0, 32'h2);
      rx_active <= 1'b0;
      poll(OFS_CTRL1, 32'h2, 32'h2);
      rd_chk(OFS_CTRL0, 32'h2);
      tx_dom <= 1'b1;
      pin_chk(P_TX, 1'b1);
      bus_dom <= 1'b1;
      pin_chk(P_RI, 1'b1);
      pin_chk(P_RN, 1'b0);
      pin_chk(P_BO, 1'b0);
      pin_chk(P_MV, 1'b0);
      repeat (20) @(posedge pclk);
      poll(OFS_CTRL1, 32'h2, 32'h2);
      bus_dom <= 1'b0;
      tx_dom <= 1'b0;
      wr(OFS_CTRL0, 32'h0);
      poll(OFS_CTRL1, 32'h2, 32'h0);
      repeat (120) @(posedge pclk);
      end_test("sleep_locked");
      wr(OFS_RIER, 32'h80);
      wr(OFS_CTRL0, 32'h6);
      repeat (4) @(posedge pclk);
      rd_chk(OFS_CTRL1, 32'h2);
      tx_dom <= 1'b1;
      bus_dom <= 1'b1;
      repeat (10) @(posedge pclk);
      bus_dom <= 1'b0;
      pin_chk(P_TX, 1'b1);
      poll(OFS_RFLG, 32'h80, 32'h80);
      pin_chk(P_WK, 1'b1);
      repeat (150) @(posedge pclk);
      poll(OFS_CTRL1, 32'h2, 32'h0);
      pin_chk(P_TX, 1'b0);
      pin_chk(P_BO, 1'b1);
      pin_chk(P_MV, 1'b1);
      wr(OFS_RFLG, 32'h80);
      poll(OFS_RFLG, 32'h80, 32'h0);
      pin_chk(P_WK, 1'b0);
      wr(OFS_CTRL0, 32'h0);
      end_test("wakeup");
      cpu_stop <= 1'b1;
      pin_chk(P_TX, 1'b1);
      cpu_stop <= 1'b0;
      pin_chk(P_TX, 1'b1);
      repeat (150) @(posedge pclk);
      pin_chk(P_TX, 1'b0);
      wr(OFS_CTRL0, 32'h20);
      cpu_wait <= 1'b1;
      pin_chk(P_TX, 1'b1);
      cpu_wait <= 1'b0;
      repeat (150) @(posedge pclk);
      pin_chk(P_TX, 1'b0);
      end_test("power_down");
      stop_test();
   end

endmodule : can_low_power_and_interrupts_tb_top
